/* hdl/swwc_pkg.sv */
`default_nettype none
package swwc_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CORE_IRQ_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_TIMER_PRESCALER_CONFIG = 8'h04;
    localparam logic [7:0] ADDR_PERIPHERAL_IRQ_ENABLE_1 = 8'h08;
    localparam logic [7:0] ADDR_PERIPHERAL_IRQ_ENABLE_2 = 8'h0C;
    localparam logic [7:0] ADDR_PERIPHERAL_IRQ_FLAGS_1 = 8'h10;
    localparam logic [7:0] ADDR_PERIPHERAL_IRQ_FLAGS_2 = 8'h14;
    localparam logic [7:0] ADDR_PORT_A_CHANGE_IRQ_ENABLE = 8'h18;
    localparam logic [7:0] ADDR_PORT_B_CHANGE_IRQ_ENABLE = 8'h1C;
    localparam logic [7:0] ADDR_CPU_STATUS = 8'h20;

    // Implemented-bit masks
    localparam logic [7:0] MASK_PERIPHERAL_2 = 8'hDF;
    localparam logic [7:0] MASK_PORT_A = 8'hEF;
    localparam logic [7:0] MASK_PORT_B = 8'hF3;

    // Reset values
    localparam logic [7:0] RST_CORE_IRQ_CONTROL = 8'h00;
    localparam logic [7:0] RST_TIMER_PRESCALER_CONFIG = 8'hFF;
    localparam logic [7:0] RST_CPU_STATUS = 8'h18;

    // Field positions
    localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
    localparam int EXT_EDGE_IRQ_ENABLE_BIT = 4;
    localparam int PIN_CHANGE_IRQ_ENABLE_BIT = 3;
    localparam int EXT_EDGE_IRQ_FLAG_BIT = 1;
    localparam int PIN_CHANGE_IRQ_FLAG_BIT = 0;
    localparam int PRESCALER_ASSIGN_BIT = 3;
    localparam int PRESCALER_RATE_LSB = 0;
    localparam int PRESCALER_RATE_W = 3;
    localparam int WATCHDOG_EXPIRY_FLAG_BIT = 4;
    localparam int POWER_DOWN_FLAG_BIT = 3;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int WDT_BASE_PERIOD_US = 18000;
    localparam int WDT_BASE_CYCLES = (WDT_BASE_PERIOD_US * 1000) / CLK_PERIOD_NS;
    localparam int WDT_CNT_W = 24;
    localparam int WDT_PRESC_W = 7;

    typedef enum logic [0:0] {
        SWWC_RUN = 1'b0,
        SWWC_SLEEP = 1'b1
    } swwc_state_t;
endpackage : swwc_pkg
`default_nettype wire

/* hdl/swwc_top.sv */
// Functional notes
// - Sleep instruction enters power-down unless irq pending
// - Watchdog cleared at sleep, keeps counting
// - Sleep entry clears power-down, sets expiry flag
// - Core clock stopped during power-down
// - Analog supply off in sleep, enables kept
// - Pins keep pre-sleep output state
// - Power-on reset wakes device from sleep
// - Five wake sources: resets, watchdog, interrupts
// - Only pin-change and edge irq wake
// - Sleep prefetches the next program address
// - Individual enable gates wake, global ignored
// - Global enable selects continue or vector
// - Watchdog cleared on every wake
// - Pending irq makes sleep a no-op
// - Late irq: full sleep, immediate wake
// - Watchdog runs only with fuse set
// - Expiry resets when running, wakes when sleeping
// - Base interval, optional prescaler up to 1:128
// - Clear and sleep instructions clear watchdog
// - Timeout clears the expiry flag
//
// Local design decisions: the placing of the registers and register access over APB.
`default_nettype none
module swwc_top #(
    parameter int WDT_BASE_CYCLES = swwc_pkg::WDT_BASE_CYCLES,
    parameter int PC_W = 12
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_exec,
    input wire logic watchdog_clear_instruction,
    input wire logic [PC_W-1:0] pc,
    input wire logic por_event,
    input wire logic external_reset_pin_n,
    input wire logic external_reset_enable,
    input wire logic watchdog_enable_fuse,
    input wire logic ext_edge_irq,
    input wire logic [7:0] pin_change_a,
    input wire logic [7:0] pin_change_b,
    input wire logic [7:0] periph_flag_set_1,
    input wire logic [7:0] periph_flag_set_2,
    input wire logic [7:0] gpio_out_core,
    input wire logic [7:0] gpio_oe_core,
    output logic [7:0] gpio_out,
    output logic [7:0] gpio_oe,
    output logic cpu_clk_en,
    output logic analog_domain_on,
    output logic device_reset_req,
    output logic resume_pulse,
    output logic isr_vector_pending,
    output logic prefetch_req,
    output logic [PC_W-1:0] prefetch_addr
);
    ////////////////////////////////////////////////////////////////////////////
    swwc_pkg::swwc_state_t state;
    logic [7:0] core_irq_control;
    logic [7:0] timer_prescaler_config;
    logic [7:0] peripheral_irq_enable_1;
    logic [7:0] peripheral_irq_enable_2;
    logic [7:0] peripheral_irq_flags_1;
    logic [7:0] peripheral_irq_flags_2;
    logic [7:0] port_a_change_irq_enable;
    logic [7:0] port_b_change_irq_enable;
    logic [7:0] cpu_status;
    logic [swwc_pkg::WDT_CNT_W-1:0] wdt_base_cnt;
    logic [swwc_pkg::WDT_PRESC_W-1:0] wdt_presc_cnt;
    logic [swwc_pkg::WDT_PRESC_W-1:0] presc_limit;
    logic wdt_fuse_q;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [7:0] wdata;
    logic [7:0] rdata_mux;
    logic pin_change_hit;
    logic wake_pending;
    logic reset_evt;
    logic wdt_expire;
    logic wdt_clear;
    logic sleep_go;
    logic sleep_nop;
    logic irq_wake;
    logic wdt_wake;
    logic [7:0] flags_1_set;
    logic [7:0] flags_2_set;

    ////////////////////////////////////////////////////////////////////////////
    // APB access decode
    assign wr_en = psel && penable && pready && pwrite;
    assign rd_en = psel && !penable;
    assign wdata = pwdata[7:0];

    always_comb begin
        addr_ok = 1'b1;
        case (paddr)
            swwc_pkg::ADDR_CORE_IRQ_CONTROL: rdata_mux = core_irq_control;
            swwc_pkg::ADDR_TIMER_PRESCALER_CONFIG: rdata_mux = timer_prescaler_config;
            swwc_pkg::ADDR_PERIPHERAL_IRQ_ENABLE_1: rdata_mux = peripheral_irq_enable_1;
            swwc_pkg::ADDR_PERIPHERAL_IRQ_ENABLE_2: rdata_mux = peripheral_irq_enable_2;
            swwc_pkg::ADDR_PERIPHERAL_IRQ_FLAGS_1: rdata_mux = peripheral_irq_flags_1;
            swwc_pkg::ADDR_PERIPHERAL_IRQ_FLAGS_2: rdata_mux = peripheral_irq_flags_2;
            swwc_pkg::ADDR_PORT_A_CHANGE_IRQ_ENABLE: rdata_mux = port_a_change_irq_enable;
            swwc_pkg::ADDR_PORT_B_CHANGE_IRQ_ENABLE: rdata_mux = port_b_change_irq_enable;
            swwc_pkg::ADDR_CPU_STATUS: rdata_mux = cpu_status;
            default: begin
                rdata_mux = 8'h00;
                addr_ok = 1'b0;
            end
        endcase
    end

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_ok;
            if (psel && penable && !pready && !pwrite) begin
                prdata <= {24'h000000, rdata_mux};
            end else if (rd_en) begin
                prdata <= 32'h00000000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake sources
    assign pin_change_hit = |((pin_change_a & port_a_change_irq_enable) |
                              (pin_change_b & port_b_change_irq_enable));
    // Only edge and pin-change flags with their own enable; global enable ignored
    assign wake_pending = (core_irq_control[swwc_pkg::EXT_EDGE_IRQ_ENABLE_BIT] &&
                           core_irq_control[swwc_pkg::EXT_EDGE_IRQ_FLAG_BIT]) ||
                          (core_irq_control[swwc_pkg::PIN_CHANGE_IRQ_ENABLE_BIT] &&
                           core_irq_control[swwc_pkg::PIN_CHANGE_IRQ_FLAG_BIT]);
    assign reset_evt = por_event || (external_reset_enable && !external_reset_pin_n);
    assign sleep_go = (state == swwc_pkg::SWWC_RUN) && sleep_exec && !wake_pending && !reset_evt;
    assign sleep_nop = (state == swwc_pkg::SWWC_RUN) && sleep_exec && wake_pending;
    assign irq_wake = (state == swwc_pkg::SWWC_SLEEP) && wake_pending && !reset_evt;
    assign wdt_wake = (state == swwc_pkg::SWWC_SLEEP) && wdt_expire && !reset_evt && !wake_pending;

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog
    always_comb begin
        if (timer_prescaler_config[swwc_pkg::PRESCALER_ASSIGN_BIT]) begin
            presc_limit = swwc_pkg::WDT_PRESC_W'((8'h01 << timer_prescaler_config[2:0]) - 8'h01);
        end else begin
            presc_limit = 7'h00;
        end
    end

    assign wdt_expire = wdt_fuse_q && (wdt_base_cnt == swwc_pkg::WDT_CNT_W'(WDT_BASE_CYCLES - 1)) &&
                        (wdt_presc_cnt >= presc_limit);
    assign wdt_clear = watchdog_clear_instruction || sleep_go || irq_wake || wdt_wake ||
                       reset_evt || wdt_expire;

    // Fuse caught while reset is held; a cleared fuse stays cleared
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wdt_fuse_q <= watchdog_enable_fuse;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wdt_base_cnt <= '0;
            wdt_presc_cnt <= '0;
        end else if (!wdt_fuse_q || wdt_clear) begin
            wdt_base_cnt <= '0;
            wdt_presc_cnt <= '0;
        end else if (wdt_base_cnt == swwc_pkg::WDT_CNT_W'(WDT_BASE_CYCLES - 1)) begin
            wdt_base_cnt <= '0;
            wdt_presc_cnt <= wdt_presc_cnt + 7'h01;
        end else begin
            wdt_base_cnt <= wdt_base_cnt + 24'h000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sleep state machine and power gating
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= swwc_pkg::SWWC_RUN;
        end else begin
            case (state)
                swwc_pkg::SWWC_RUN: begin
                    if (sleep_go) begin
                        state <= swwc_pkg::SWWC_SLEEP;
                    end
                end
                swwc_pkg::SWWC_SLEEP: begin
                    if (reset_evt || irq_wake || wdt_wake) begin
                        state <= swwc_pkg::SWWC_RUN;
                    end
                end
                default: state <= swwc_pkg::SWWC_RUN;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cpu_clk_en <= 1'b1;
            analog_domain_on <= 1'b1;
        end else if (sleep_go) begin
            cpu_clk_en <= 1'b0;
            analog_domain_on <= 1'b0;
        end else if (state == swwc_pkg::SWWC_SLEEP && (reset_evt || irq_wake || wdt_wake)) begin
            cpu_clk_en <= 1'b1;
            analog_domain_on <= 1'b1;
        end
    end

    // Pin drivers frozen while asleep
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            gpio_out <= 8'h00;
            gpio_oe <= 8'h00;
        end else if (state == swwc_pkg::SWWC_RUN && !sleep_go) begin
            gpio_out <= gpio_out_core;
            gpio_oe <= gpio_oe_core;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            device_reset_req <= 1'b0;
            resume_pulse <= 1'b0;
            isr_vector_pending <= 1'b0;
        end else begin
            device_reset_req <= reset_evt || (wdt_expire && state == swwc_pkg::SWWC_RUN);
            resume_pulse <= irq_wake || wdt_wake;
            if (reset_evt) begin
                isr_vector_pending <= 1'b0;
            end else if (irq_wake) begin
                isr_vector_pending <= core_irq_control[swwc_pkg::GLOBAL_IRQ_ENABLE_BIT];
            end else if (state == swwc_pkg::SWWC_RUN && !sleep_go) begin
                isr_vector_pending <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prefetch_req <= 1'b0;
            prefetch_addr <= '0;
        end else begin
            prefetch_req <= sleep_exec && state == swwc_pkg::SWWC_RUN;
            if (sleep_exec && state == swwc_pkg::SWWC_RUN) begin
                prefetch_addr <= pc + PC_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers; hardware set wins over a software clear
    assign flags_1_set = periph_flag_set_1;
    assign flags_2_set = periph_flag_set_2 & swwc_pkg::MASK_PERIPHERAL_2;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            core_irq_control <= swwc_pkg::RST_CORE_IRQ_CONTROL;
        end else begin
            if (wr_en && paddr == swwc_pkg::ADDR_CORE_IRQ_CONTROL) begin
                core_irq_control <= wdata;
            end
            if (ext_edge_irq) begin
                core_irq_control[swwc_pkg::EXT_EDGE_IRQ_FLAG_BIT] <= 1'b1;
            end
            if (pin_change_hit) begin
                core_irq_control[swwc_pkg::PIN_CHANGE_IRQ_FLAG_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            timer_prescaler_config <= swwc_pkg::RST_TIMER_PRESCALER_CONFIG;
            peripheral_irq_enable_1 <= 8'h00;
            peripheral_irq_enable_2 <= 8'h00;
            port_a_change_irq_enable <= 8'h00;
            port_b_change_irq_enable <= 8'h00;
        end else if (wr_en) begin
            case (paddr)
                swwc_pkg::ADDR_TIMER_PRESCALER_CONFIG: timer_prescaler_config <= wdata;
                swwc_pkg::ADDR_PERIPHERAL_IRQ_ENABLE_1: peripheral_irq_enable_1 <= wdata;
                swwc_pkg::ADDR_PERIPHERAL_IRQ_ENABLE_2: peripheral_irq_enable_2 <= wdata & swwc_pkg::MASK_PERIPHERAL_2;
                swwc_pkg::ADDR_PORT_A_CHANGE_IRQ_ENABLE: port_a_change_irq_enable <= wdata & swwc_pkg::MASK_PORT_A;
                swwc_pkg::ADDR_PORT_B_CHANGE_IRQ_ENABLE: port_b_change_irq_enable <= wdata & swwc_pkg::MASK_PORT_B;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            peripheral_irq_flags_1 <= 8'h00;
            peripheral_irq_flags_2 <= 8'h00;
        end else begin
            if (wr_en && paddr == swwc_pkg::ADDR_PERIPHERAL_IRQ_FLAGS_1) begin
                peripheral_irq_flags_1 <= wdata | flags_1_set;
            end else begin
                peripheral_irq_flags_1 <= peripheral_irq_flags_1 | flags_1_set;
            end
            if (wr_en && paddr == swwc_pkg::ADDR_PERIPHERAL_IRQ_FLAGS_2) begin
                peripheral_irq_flags_2 <= (wdata & swwc_pkg::MASK_PERIPHERAL_2) | flags_2_set;
            end else begin
                peripheral_irq_flags_2 <= peripheral_irq_flags_2 | flags_2_set;
            end
        end
    end

    // Status: flag bits owned by hardware, the rest writable
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cpu_status <= swwc_pkg::RST_CPU_STATUS;
        end else begin
            if (wr_en && paddr == swwc_pkg::ADDR_CPU_STATUS) begin
                cpu_status[7:5] <= wdata[7:5];
                cpu_status[2:0] <= wdata[2:0];
            end
            if (por_event) begin
                cpu_status[swwc_pkg::WATCHDOG_EXPIRY_FLAG_BIT] <= 1'b1;
                cpu_status[swwc_pkg::POWER_DOWN_FLAG_BIT] <= 1'b1;
            end else if (wdt_expire) begin
                cpu_status[swwc_pkg::WATCHDOG_EXPIRY_FLAG_BIT] <= 1'b0;
            end else if (sleep_go) begin
                cpu_status[swwc_pkg::WATCHDOG_EXPIRY_FLAG_BIT] <= 1'b1;
                cpu_status[swwc_pkg::POWER_DOWN_FLAG_BIT] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_sleep_entry: assert property (sleep_go |=> state == swwc_pkg::SWWC_SLEEP &&
        !cpu_status[swwc_pkg::POWER_DOWN_FLAG_BIT] && cpu_status[swwc_pkg::WATCHDOG_EXPIRY_FLAG_BIT]
        && wdt_base_cnt == '0)
        else $error("sleep entry flags or state wrong");
    a_sleep_noop: assert property (sleep_nop && !reset_evt && !wdt_expire |=>
        state == swwc_pkg::SWWC_RUN && $stable(cpu_status[4:3]) && cpu_clk_en)
        else $error("pending irq sleep not a no-op");
    a_clock_gated: assert property (state == swwc_pkg::SWWC_SLEEP |-> !cpu_clk_en && !analog_domain_on)
        else $error("core clock running in sleep");
    a_gpio_frozen: assert property (state == swwc_pkg::SWWC_SLEEP && $past(state) == swwc_pkg::SWWC_SLEEP
        |-> $stable(gpio_out) && $stable(gpio_oe))
        else $error("pin state moved during sleep");
    a_por_wakes: assert property (por_event && state == swwc_pkg::SWWC_SLEEP |=>
        state == swwc_pkg::SWWC_RUN && device_reset_req && cpu_clk_en)
        else $error("power-on reset did not wake");
    a_irq_wake: assert property (irq_wake |=> state == swwc_pkg::SWWC_RUN && resume_pulse
        && wdt_base_cnt == '0 ##1 !resume_pulse)
        else $error("interrupt wake sequence wrong");
    a_wdt_reset: assert property (wdt_expire && state == swwc_pkg::SWWC_RUN && !por_event |=>
        device_reset_req && !cpu_status[swwc_pkg::WATCHDOG_EXPIRY_FLAG_BIT] && !resume_pulse)
        else $error("watchdog expiry did not reset");
    a_prefetch_next: assert property (sleep_go |=> prefetch_req && prefetch_addr == $past(pc) + PC_W'(1))
        else $error("prefetch address not pc plus one");
    a_fuse_off: assert property (!wdt_fuse_q |-> wdt_base_cnt == '0 && !wdt_expire)
        else $error("watchdog counts with fuse cleared");

    c_sleep_irq_wake: cover property (sleep_go ##[1:20] irq_wake);
    c_sleep_wdt_wake: cover property (sleep_go ##[1:1000] wdt_wake);
    c_sleep_noop: cover property (sleep_nop);
    c_run_wdt_reset: cover property (wdt_expire && state == swwc_pkg::SWWC_RUN);
endmodule : swwc_top
`default_nettype wire

/* dv/swwc_core_model.sv */
`default_nettype none
module swwc_core_model #(
    parameter int PC_W = 12
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cpu_clk_en,
    input wire logic do_sleep,
    input wire logic do_clear,
    output logic sleep_exec,
    output logic watchdog_clear_instruction,
    output logic [PC_W-1:0] pc,
    output logic [7:0] gpio_out_core,
    output logic [7:0] gpio_oe_core
);
    timeunit 1ns;
    timeprecision 1ns;
    // Instructions issue only while the core clock runs
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sleep_exec <= 1'b0;
            watchdog_clear_instruction <= 1'b0;
            pc <= '0;
        end else begin
            sleep_exec <= do_sleep && cpu_clk_en;
            watchdog_clear_instruction <= do_clear && cpu_clk_en;
            // PC holds while the core clock is stopped
            pc <= cpu_clk_en ? pc + 1'b1 : pc;
        end
    end
    // Pin pattern keeps moving so a missing hold shows
    always_ff @(posedge mclk) begin
        gpio_out_core <= rst_n ? gpio_out_core + 8'h01 : 8'h5A;
        gpio_oe_core <= rst_n ? ~gpio_oe_core : 8'h0F;
    end
endmodule : swwc_core_model
`default_nettype wire

/* dv/swwc_top_test.sv */
`default_nettype none
module swwc_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PC_W = 12;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic por_event = 1'b0;
    logic pin_n = 1'b1;
    logic pin_en = 1'b0;
    logic fuse = 1'b0;
    logic ext_irq = 1'b0;
    logic [7:0] pca = 8'h00, pcb = 8'h00;
    logic [7:0] pfs = 8'h00, pfs2 = 8'h00;
    logic do_sleep = 1'b0;
    logic do_clear = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, sleep_exec, wclr, cpu_clk_en, analog_on, rst_req, resume, isr, pf_req;
    logic [PC_W-1:0] pc, pf_addr, sl_pc;
    logic [7:0] go_c, oe_c, go, oe, g;
    logic [33:0] apb_q[$];
    logic [2:0] ev_q[$];
    logic [33:0] e;
    logic [7:0] r;
    int err_total = 0;
    int checked = 0;

    always #50 mclk = ~mclk;

    swwc_top #(.WDT_BASE_CYCLES(20), .PC_W(PC_W)) i_swwc_top (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_exec(sleep_exec), .watchdog_clear_instruction(wclr), .pc(pc),
        .por_event(por_event), .external_reset_pin_n(pin_n), .external_reset_enable(pin_en),
        .watchdog_enable_fuse(fuse), .ext_edge_irq(ext_irq), .pin_change_a(pca), .pin_change_b(pcb),
        .periph_flag_set_1(pfs), .periph_flag_set_2(pfs2), .gpio_out_core(go_c), .gpio_oe_core(oe_c),
        .gpio_out(go), .gpio_oe(oe), .cpu_clk_en(cpu_clk_en), .analog_domain_on(analog_on),
        .device_reset_req(rst_req), .resume_pulse(resume), .isr_vector_pending(isr),
        .prefetch_req(pf_req), .prefetch_addr(pf_addr));

    swwc_core_model #(.PC_W(PC_W)) i_swwc_core_model (.mclk(mclk), .rst_n(rst_n), .cpu_clk_en(cpu_clk_en),
        .do_sleep(do_sleep), .do_clear(do_clear), .sleep_exec(sleep_exec), .watchdog_clear_instruction(wclr),
        .pc(pc), .gpio_out_core(go_c), .gpio_oe_core(oe_c));

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic er);
        int n;
        n = 0;
        apb_q.push_back({w, er, d});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge mclk);
            n++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16) begin
            chk("pready", 32'h0, 32'h1);
            apb_q.delete();
        end
        @(posedge mclk);
    endtask : apb

    task automatic go_sleep;
        do_sleep <= 1'b1;
        @(posedge mclk);
        do_sleep <= 1'b0;
    endtask : go_sleep

    task automatic await_ev(input int lim);
        int n;
        n = 0;
        while (ev_q.size() != 0 && n < lim) begin
            @(posedge mclk);
            n++;
        end
        if (ev_q.size() != 0) begin
            chk("event_missing", 32'h0, 32'h1);
            ev_q.delete();
        end
    endtask : await_ev

    task automatic reset_dut(input logic f);
        rst_n <= 1'b0;
        fuse <= f;
        cyc(8);
        rst_n <= 1'b1;
        cyc(1);
    endtask : reset_dut

    ////////////////////////////////////////////////////////////////
    // Result watcher against queued notes
    always @(posedge mclk) begin
        if (rst_n && psel && penable && pready === 1'b1) begin
            e = apb_q.size() != 0 ? apb_q.pop_front() : 34'h3_0000_0000;
            chk("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
            if (!e[33]) chk("prdata", prdata, e[31:0]);
        end
        if (rst_n && (resume === 1'b1 || rst_req === 1'b1)) begin
            chk("wake_event", {29'h0, rst_req, resume, isr}, {29'h0, ev_q.size() != 0 ? ev_q.pop_front() : 3'h0});
        end
        if (sleep_exec === 1'b1 && cpu_clk_en === 1'b1) sl_pc = pc;
        if (pf_req === 1'b1) chk("prefetch_addr", 32'(pf_addr), 32'(PC_W'(sl_pc + 1'b1)));
    end

    initial begin
        repeat (4000) @(posedge mclk);
        err_total++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hA763));
        r = 8'($urandom());
        reset_dut(1'b0);
        apb(1'b0, swwc_pkg::ADDR_TIMER_PRESCALER_CONFIG, 32'hFF, 1'b0);
        apb(1'b1, swwc_pkg::ADDR_CPU_STATUS, 32'h00, 1'b0);
        apb(1'b0, swwc_pkg::ADDR_CPU_STATUS, 32'h18, 1'b0);
        apb(1'b1, 8'h24, 32'h5A, 1'b1);
        apb(1'b0, 8'h24, 32'h0, 1'b1);
        apb(1'b1, swwc_pkg::ADDR_PERIPHERAL_IRQ_ENABLE_1, {24'h0, r}, 1'b0);
        apb(1'b0, swwc_pkg::ADDR_PERIPHERAL_IRQ_ENABLE_1, {24'h0, r}, 1'b0);
        apb(1'b1, swwc_pkg::ADDR_PORT_B_CHANGE_IRQ_ENABLE, 32'hFF, 1'b0);
        apb(1'b0, swwc_pkg::ADDR_PORT_B_CHANGE_IRQ_ENABLE, {24'h0, swwc_pkg::MASK_PORT_B}, 1'b0);
        // Fuse off: no expiry even at 1x
        apb(1'b1, swwc_pkg::ADDR_TIMER_PRESCALER_CONFIG, 32'h00, 1'b0);
        cyc(60);
        // Pending enabled flag turns sleep into a no-op
        apb(1'b1, swwc_pkg::ADDR_CORE_IRQ_CONTROL, 32'h10, 1'b0);
        ext_irq <= 1'b1;
        cyc(1);
        ext_irq <= 1'b0;
        apb(1'b0, swwc_pkg::ADDR_CORE_IRQ_CONTROL, 32'h12, 1'b0);
        go_sleep();
        cyc(4);
        chk("cpu_clk_en", {31'h0, cpu_clk_en}, 32'h1);
        apb(1'b0, swwc_pkg::ADDR_CPU_STATUS, 32'h18, 1'b0);
        // Real sleep, edge wake with global enable off
        apb(1'b1, swwc_pkg::ADDR_CORE_IRQ_CONTROL, 32'h10, 1'b0);
        go_sleep();
        cyc(3);
        chk("clk_analog", {30'h0, cpu_clk_en, analog_on}, 32'h0);
        apb(1'b0, swwc_pkg::ADDR_CPU_STATUS, 32'h10, 1'b0);
        g = go;
        pfs <= r | 8'h01;
        pfs2 <= 8'hFF;
        cyc(1);
        pfs <= 8'h00;
        pfs2 <= 8'h00;
        cyc(5);
        chk("gpio_hold", {16'h0, go, oe}, {16'h0, g, oe});
        apb(1'b0, swwc_pkg::ADDR_PERIPHERAL_IRQ_FLAGS_2, 32'hDF, 1'b0);
        chk("asleep_periph", {31'h0, cpu_clk_en}, 32'h0);
        ev_q.push_back(3'b010);
        ext_irq <= 1'b1;
        cyc(1);
        ext_irq <= 1'b0;
        await_ev(8);
        chk("analog_back", {31'h0, analog_on}, 32'h1);
        // Disabled edge ignored; pin change wakes and vectors
        apb(1'b1, swwc_pkg::ADDR_CORE_IRQ_CONTROL, 32'h88, 1'b0);
        apb(1'b1, swwc_pkg::ADDR_PORT_A_CHANGE_IRQ_ENABLE, 32'h01, 1'b0);
        go_sleep();
        cyc(2);
        ext_irq <= 1'b1;
        pcb <= 8'h0C;
        cyc(1);
        ext_irq <= 1'b0;
        pcb <= 8'h00;
        cyc(4);
        chk("asleep_masked", {31'h0, cpu_clk_en}, 32'h0);
        ev_q.push_back(3'b011);
        pca <= 8'h01;
        cyc(1);
        pca <= 8'h00;
        await_ev(8);
        // Flag raised with the sleep itself
        apb(1'b1, swwc_pkg::ADDR_CORE_IRQ_CONTROL, 32'h10, 1'b0);
        ev_q.push_back(3'b010);
        go_sleep();
        ext_irq <= 1'b1;
        cyc(1);
        ext_irq <= 1'b0;
        await_ev(8);
        apb(1'b0, swwc_pkg::ADDR_CPU_STATUS, 32'h10, 1'b0);
        // Reset pin only when enabled, then power-on event
        apb(1'b1, swwc_pkg::ADDR_CORE_IRQ_CONTROL, 32'h00, 1'b0);
        go_sleep();
        cyc(3);
        pin_n <= 1'b0;
        cyc(1);
        pin_n <= 1'b1;
        cyc(4);
        chk("pin_disabled", {31'h0, cpu_clk_en}, 32'h0);
        pin_en <= 1'b1;
        ev_q.push_back(3'b100);
        pin_n <= 1'b0;
        cyc(1);
        pin_n <= 1'b1;
        await_ev(8);
        cyc(2);
        chk("run_after_pin", {31'h0, cpu_clk_en}, 32'h1);
        go_sleep();
        cyc(3);
        ev_q.push_back(3'b100);
        por_event <= 1'b1;
        cyc(1);
        por_event <= 1'b0;
        await_ev(8);
        apb(1'b0, swwc_pkg::ADDR_CPU_STATUS, 32'h18, 1'b0);
        // Watchdog: clears hold it off, then 2x expiry in run
        reset_dut(1'b1);
        apb(1'b1, swwc_pkg::ADDR_TIMER_PRESCALER_CONFIG, 32'h09, 1'b0);
        repeat (3) begin
            do_clear <= 1'b1;
            cyc(1);
            do_clear <= 1'b0;
            cyc(30);
        end
        cyc(4);
        ev_q.push_back(3'b100);
        await_ev(20);
        apb(1'b0, swwc_pkg::ADDR_CPU_STATUS, 32'h08, 1'b0);
        apb(1'b1, swwc_pkg::ADDR_TIMER_PRESCALER_CONFIG, 32'h00, 1'b0);
        go_sleep();
        cyc(14);
        chk("wdt_cleared_sleep", {31'h0, cpu_clk_en}, 32'h0);
        ev_q.push_back(3'b010);
        await_ev(12);
        cyc(15);
        ev_q.push_back(3'b100);
        await_ev(12);
        apb(1'b0, swwc_pkg::ADDR_CPU_STATUS, 32'h00, 1'b0);
        close_out();
    end
endmodule : swwc_top_test
`default_nettype wire
